// >>> pkg/tcr_cfg.svh
// Constants for the temperature conversion readout block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH
`define TCR_CMD_CONVERT     8'h44
`define TCR_FUNC_TRIGGER    2'h3
`define TCR_FUNC_OUTPUT     2'h1
`define TCR_FUNC_HIZ        2'h0
`define TCR_FUNC_PULLDOWN   2'h2
`define TCR_FIFO_DEPTH      32
`define TCR_RESULT_W        16
`define TCR_SERIAL_W        64
`define TCR_CONVERSION_TRIGGER_IN_TIME_US    16
`define TCR_CLK_MHZ         200
`define TCR_HIGH_THR_RST    16'h7FFF
`define TCR_LOW_THR_RST     16'h8000
`define TCR_STEP_MILLI_C    5
`endif

// >>> pkg/tcr_pkg.sv
// Types for the temperature conversion readout block.
// Assumes tcr_cfg.svh is on the include path.
`include "tcr_cfg.svh"
package tcr_pkg;
  typedef enum logic [2:0] {
    TCR_STANDBY = 3'b001,
    TCR_MEASURE = 3'b010,
    TCR_STORE   = 3'b100
  } tcr_state_t;

  // Result word, value counts 0.005 C per step
  typedef struct packed {
    logic [`TCR_RESULT_W-1:0] value;
  } tcr_result_t;

  // One pin: output level and active-low output enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } tcr_pin_drive_t;
endpackage : tcr_pkg

// >>> design/tcr_sync_edge.sv
// Two-stage synchroniser with rising edge detector.
// Assumes an asynchronous pin input and a single system clock.
`timescale 1ns/1ps
module tcr_sync_edge (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // First stage is read only by the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
endmodule : tcr_sync_edge

// >>> design/tcr_readout.sv
// Conversion control, result FIFO, thresholds, serial code and GP pin logic.
// Assumes a bus front end that decodes commands and reads FIFO words, and an
// analog core that delivers one sample when asked.
`timescale 1ns/1ps
`include "tcr_cfg.svh"
// Summary of operation
// [RQ1] After reset the block idles in standby with no conversion running.
// [RQ2] Convert command from the bus starts a conversion from standby.
// [RQ3] Pin 1 rising edge starts a conversion when its trigger function is chosen.
// [RQ4] Master keeps the data line high with strong pullup during conversion.
// [RQ5] Finished conversion pushes one two-byte word, then block returns to standby.
// [RQ6] FIFO holds up to thirty-two words, read out through the bus front end.
// [RQ7] Result is a signed 16-bit two's complement word, sign in the MSB.
// [RQ8] One count equals 0.005 degrees Celsius.
// [RQ9] A fixed 64-bit serial code identifies the device.
// [RQ10] High and low thresholds are volatile and reset to defaults.
// [RQ11] Pin levels in input mode read back as location address bits.
// [RQ12] Pin 0 in special mode is an open-drain active-low interrupt.
// [RQ13] Each pin may be an input or an output; pin 2 has no special mode.
// [RQ14] Bus data line is only pulled low or released.
// [RQ15] Pin 1 function field value 11 selects the conversion trigger.
// [RQ16] Pin 0 interrupt follows the enabled alarm condition.
// [RQ17] Requests during a running conversion are ignored; one result is stored.
// [RQ18] Pin 1 is synchronised and edge detected, one request per edge.
module tcr_readout
  import tcr_pkg::*;
#(
  parameter int                  CONVERSION_TRIGGER_IN_CYCLES = `TCR_CONVERSION_TRIGGER_IN_TIME_US * `TCR_CLK_MHZ * 1000,
  parameter int                  DEPTH       = `TCR_FIFO_DEPTH,
  parameter logic [`TCR_SERIAL_W-1:0] SERIAL_CODE = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      cmd_valid,
  input  wire logic [7:0]                cmd_code,
  input  wire logic                      adc_valid,
  input  wire logic [`TCR_RESULT_W-1:0]  adc_data,
  input  wire logic                      fifo_pop,
  input  wire logic                      thr_we,
  input  wire logic                      thr_sel_high,
  input  wire logic [`TCR_RESULT_W-1:0]  thr_wdata,
  input  wire logic                      alarm_flag,
  input  wire logic [1:0]                pin0_function_select,
  input  wire logic [1:0]                pin1_function_select,
  input  wire logic [1:0]                pin2_function_select,
  input  wire logic [2:0]                gp_out_level,
  input  wire logic                      gp_pin_0_in,
  input  wire logic                      gp_pin_1_in,
  input  wire logic                      gp_pin_2_in,
  input  wire logic                      dq_pull_low,
  output logic                           gp_pin_0_out,
  output logic                           gp_pin_0_oe_n,
  output logic                           gp_pin_1_out,
  output logic                           gp_pin_1_oe_n,
  output logic                           gp_pin_2_out,
  output logic                           gp_pin_2_oe_n,
  output logic                           dq_out,
  output logic                           dq_oe_n,
  output logic                           adc_start,
  output logic                           busy,
  output logic [`TCR_RESULT_W-1:0]       fifo_rdata,
  output logic                           fifo_empty,
  output logic                           fifo_full,
  output logic [5:0]                     fifo_count,
  output logic [2:0]                     location_addr,
  output logic [`TCR_SERIAL_W-1:0]       serial_code,
  output logic [`TCR_RESULT_W-1:0]       high_threshold,
  output logic [`TCR_RESULT_W-1:0]       low_threshold
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic is_input(input logic [1:0] f);
    is_input = (f == `TCR_FUNC_HIZ) || (f == `TCR_FUNC_PULLDOWN);
  endfunction : is_input

  tcr_state_t              state_reg;
  tcr_state_t              state_next;
  logic [31:0]             timer_reg;
  tcr_result_t             sample_reg;
  tcr_result_t             mem_reg [DEPTH];
  logic [AW-1:0]           wr_ptr_reg;
  logic [AW-1:0]           rd_ptr_reg;
  logic [5:0]              count_reg;
  logic [1:0]              sync0_reg;
  logic [1:0]              sync2_reg;
  logic                    pin1_level;
  logic                    pin1_rise;
  logic                    start_req;
  logic                    push;
  logic                    pop;
  logic                    sample_ok;

  tcr_sync_edge u_pin1_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (gp_pin_1_in),
    .level    (pin1_level),
    .rise     (pin1_rise)       // RQ18
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync0_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else begin
      sync0_reg <= {sync0_reg[0], gp_pin_0_in};
      sync2_reg <= {sync2_reg[0], gp_pin_2_in};
    end
  end

  assign start_req = (cmd_valid && cmd_code == `TCR_CMD_CONVERT) // RQ2
                  || (pin1_rise && pin1_function_select == `TCR_FUNC_TRIGGER); // RQ3 RQ15

  // Master holds the line high during measure, so no bus traffic is expected here
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TCR_STANDBY: if (start_req) state_next = TCR_MEASURE; // RQ1 RQ2 RQ3
      TCR_MEASURE: if (sample_ok) state_next = TCR_STORE; // RQ4 RQ17
      TCR_STORE:   state_next = TCR_STANDBY; // RQ5
      default:     state_next = TCR_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) state_reg <= TCR_STANDBY; // RQ1
    else        state_reg <= state_next;
  end

  // Timer bounds the wait if the analog core never answers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg  <= 32'h0000_0000;
      sample_reg <= '0;
      adc_start  <= 1'b0;
    end else begin
      adc_start <= (state_reg == TCR_STANDBY) && start_req;
      if (state_reg != TCR_MEASURE) begin
        timer_reg <= 32'h0000_0000;
      end else begin
        timer_reg <= timer_reg + 32'h0000_0001;
      end
      if (state_reg == TCR_MEASURE && adc_valid) begin
        sample_reg.value <= adc_data; // RQ7 RQ8
      end
    end
  end

  assign sample_ok = adc_valid || (timer_reg >= 32'(CONVERSION_TRIGGER_IN_CYCLES - 1));

  // Full FIFO drops the new word rather than overwriting unread history
  assign push = (state_reg == TCR_STORE) && (count_reg != 6'(DEPTH)); // RQ5 RQ6
  assign pop  = fifo_pop && (count_reg != 6'h00);

  always_ff @(posedge sys_clk) begin
    if (push) mem_reg[wr_ptr_reg] <= sample_reg; // RQ6
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= 6'h00;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + 6'(push) - 6'(pop);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_rdata <= '0;
      fifo_empty <= 1'b1;
      fifo_full  <= 1'b0;
      fifo_count <= 6'h00;
      busy       <= 1'b0;
    end else begin
      fifo_rdata <= mem_reg[rd_ptr_reg].value;
      fifo_empty <= (count_reg == 6'h00);
      fifo_full  <= (count_reg == 6'(DEPTH));
      fifo_count <= count_reg;
      busy       <= (state_reg != TCR_STANDBY);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_threshold <= `TCR_HIGH_THR_RST; // RQ10
      low_threshold  <= `TCR_LOW_THR_RST; // RQ10
      serial_code    <= '0;
    end else begin
      serial_code <= SERIAL_CODE; // RQ9
      if (thr_we && thr_sel_high)  high_threshold <= thr_wdata;
      if (thr_we && !thr_sel_high) low_threshold  <= thr_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      location_addr <= 3'h0;
      gp_pin_0_out  <= 1'b0;
      gp_pin_0_oe_n <= 1'b1;
      gp_pin_1_out  <= 1'b0;
      gp_pin_1_oe_n <= 1'b1;
      gp_pin_2_out  <= 1'b0;
      gp_pin_2_oe_n <= 1'b1;
      dq_out        <= 1'b0;
      dq_oe_n       <= 1'b1;
    end else begin
      location_addr <= {is_input(pin2_function_select) & sync2_reg[1],
                        is_input(pin1_function_select) & pin1_level,
                        is_input(pin0_function_select) & sync0_reg[1]}; // RQ11
      // Open drain: drive only low, release otherwise
      gp_pin_0_oe_n <= ~(((pin0_function_select == `TCR_FUNC_OUTPUT) && !gp_out_level[0])
                      || ((pin0_function_select == `TCR_FUNC_TRIGGER) && alarm_flag)); // RQ12 RQ16
      gp_pin_1_oe_n <= ~((pin1_function_select == `TCR_FUNC_OUTPUT) && !gp_out_level[1]); // RQ13
      gp_pin_2_oe_n <= ~((pin2_function_select == `TCR_FUNC_OUTPUT) && !gp_out_level[2]); // RQ13
      dq_oe_n       <= ~dq_pull_low; // RQ14
    end
  end
endmodule : tcr_readout

// >>> test/tcr_readout_props.sv
// Checker for the readout block: start, store, fill and data line relations.
// Assumes binding onto every tcr_readout instance.
`timescale 1ns/1ps
`include "tcr_cfg.svh"
module tcr_readout_props (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       adc_valid,
  input wire logic       fifo_pop,
  input wire logic       dq_pull_low,
  input wire logic       dq_out,
  input wire logic       dq_oe_n,
  input wire logic       adc_start,
  input wire logic       busy,
  input wire logic       fifo_empty,
  input wire logic       fifo_full,
  input wire logic [5:0] fifo_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  cmd_start_a: assert property (!busy && !adc_start && cmd_valid
    && cmd_code == `TCR_CMD_CONVERT |=> adc_start ##1 busy)
    else $error("convert command not taken");
  one_start_a: assert property (adc_start |-> !$past(busy))
    else $error("start while busy");
  start_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("start longer than one cycle");
  store_word_a: assert property (busy && adc_valid && !fifo_full && !fifo_pop ##1 !fifo_pop
    |=> ##1 fifo_count == $past(fifo_count) + 6'h1) else $error("result not stored");
  back_idle_a: assert property (busy && adc_valid |-> ##3 !busy)
    else $error("no return to standby");
  fill_flags_a: assert property (fifo_empty == (fifo_count == 6'h0)
    && fifo_full == (fifo_count == 6'h20) && fifo_count <= 6'h20) else $error("fill flags");
  dq_drive_a: assert property (dq_pull_low |=> !dq_oe_n && !dq_out)
    else $error("data line not pulled low");
  dq_release_a: assert property (!dq_pull_low |=> dq_oe_n)
    else $error("data line not released");
  cover property (busy && cmd_valid);
  cover property (fifo_full);
  cover property (adc_start && !cmd_valid);
endmodule : tcr_readout_props

bind tcr_readout tcr_readout_props props_u (.*);

// >>> test/tcr_adc_model.sv
// Analog core stand-in: answers each start with one sample after a delay.
// Assumes one-cycle start pulses; data toggles while not valid.
`timescale 1ns/1ps
module tcr_adc_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        adc_start,
  input  wire logic [7:0]  delay,
  input  wire logic [15:0] sample,
  output logic             adc_valid,
  output logic [15:0]      adc_data
);
  logic [7:0] wait_reg;
  logic       run_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg   <= 1'h0;
      wait_reg  <= 8'h00;
      adc_valid <= 1'h0;
      adc_data  <= 16'h0000;
    end else if (adc_start) begin
      run_reg   <= 1'h1;
      wait_reg  <= delay;
      adc_valid <= 1'h0;
    end else if (run_reg && wait_reg == 8'h00) begin
      run_reg   <= 1'h0;
      adc_valid <= 1'h1;
      adc_data  <= sample;
    end else begin
      // Stale data never looks valid
      wait_reg  <= wait_reg - 8'h01;
      adc_valid <= 1'h0;
      adc_data  <= ~adc_data;
    end
  end
endmodule : tcr_adc_model

// >>> test/tb.sv
// Self-checking bench for the readout block.
// Assumes the analog stand-in and a 200 MHz clock.
`timescale 1ns/1ps
`include "tcr_cfg.svh"
module tb;
  import tcr_pkg::*;
  typedef struct packed {logic pin; int mc; logic [15:0] word;} tcr_row_t;
  localparam logic [63:0] SERIAL = 64'h5A5A_0F0F_3C3C_A5A5; // Arbitrary value
  logic sys_clk = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, fifo_pop = 1'h0, thr_we = 1'h0;
  logic thr_sel_high = 1'h0, alarm_flag = 1'h0, dq_pull_low = 1'h0, gp_pin_0_in = 1'h0;
  logic gp_pin_1_in = 1'h0, gp_pin_2_in = 1'h1, adc_valid, dq_out, dq_oe_n, adc_start, busy;
  logic [7:0] cmd_code = 8'h00, delay = 8'h03;
  logic [15:0] sample = 16'h0000, thr_wdata = 16'h0000, adc_data, fifo_rdata;
  logic [15:0] high_threshold, low_threshold;
  logic [1:0] pin0_function_select = 2'h2, pin1_function_select = 2'h3;
  logic [1:0] pin2_function_select = 2'h2;
  logic [2:0] gp_out_level = 3'h7, location_addr;
  logic gp_pin_0_out, gp_pin_0_oe_n, gp_pin_1_out, gp_pin_1_oe_n, gp_pin_2_out, gp_pin_2_oe_n;
  logic fifo_empty, fifo_full;
  logic [5:0] fifo_count;
  logic [63:0] serial_code;
  int bad_count = 0, n_compared = 0;
  tcr_row_t rows [4] = '{'{1'h0, 37000, 16'h1CE8}, '{1'h1, -1000, 16'hFF38},
                         '{1'h0, -5, 16'hFFFF}, '{1'h1, 70000, 16'h36B0}};
  tcr_readout #(.CONVERSION_TRIGGER_IN_CYCLES(60), .SERIAL_CODE(SERIAL)) dut_u (.*);
  tcr_adc_model adc_u (.*);
  always #2.5 sys_clk = ~sys_clk;
  task automatic tk(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tk
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wt;
    for (int i = 0; i < 100 && busy !== 1'h0; i++) tk(1);
  endtask : wt
  task automatic pulse_cmd;
    cmd_valid = 1'h1;
    cmd_code = `TCR_CMD_CONVERT;
    tk(1);
    cmd_valid = 1'h0;
  endtask : pulse_cmd
  task automatic conversion_trigger_in(logic pin, logic [15:0] s);
    sample = s;
    // Data line stays released while converting
    if (pin) gp_pin_1_in = 1'h1;
    else pulse_cmd();
    tk(6);
    wt();
    gp_pin_1_in = 1'h0;
    tk(2);
  endtask : conversion_trigger_in
  task automatic pop;
    fifo_pop = 1'h1;
    tk(1);
    fifo_pop = 1'h0;
    tk(1);
  endtask : pop
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    #30000;
    bad_count++;
    end_sim();
  end
  initial begin
    tk(6);
    chk("reset", 5'h0F, {busy, fifo_empty, gp_pin_0_oe_n, gp_pin_2_oe_n, dq_oe_n});
    chk("thresholds", 32'h7FFF_8000, {high_threshold, low_threshold});
    rst_n = 1'h1;
    tk(20);
    chk("serial", SERIAL, serial_code);
    chk("idle", 2'h1, {busy, fifo_empty});
    foreach (rows[i]) begin
      conversion_trigger_in(rows[i].pin, 16'(rows[i].mc / 5));
      chk("word", rows[i].word, fifo_rdata);
      pop();
    end
    chk("drained", 7'h40, {fifo_empty, fifo_count});
    delay = 8'h14;
    sample = 16'h0008;
    pulse_cmd();
    tk(3);
    pulse_cmd();
    wt();
    tk(2);
    chk("single", 22'h01_0008, {fifo_count, fifo_rdata});
    pop();
    delay = 8'h01;
    repeat (33) conversion_trigger_in(1'h0, 16'h0004);
    chk("full", 7'h60, {fifo_full, fifo_count});
    repeat (33) pop();
    chk("empty", 7'h40, {fifo_empty, fifo_count});
    pin0_function_select = 2'h3;
    pin1_function_select = 2'h0;
    alarm_flag = 1'h1;
    gp_pin_1_in = 1'h1;
    tk(6);
    chk("pins", 6'h06, {gp_pin_0_oe_n, gp_pin_0_out, busy, location_addr});
    pin1_function_select = 2'h1;
    pin2_function_select = 2'h1;
    gp_out_level = 3'h3;
    tk(3);
    chk("gp outs", 4'h2, {gp_pin_2_oe_n, gp_pin_2_out, gp_pin_1_oe_n, gp_pin_1_out});
    chk("loc outs", 3'h0, location_addr);
    gp_out_level = 3'h5;
    tk(2);
    chk("pin1 low", 2'h0, {gp_pin_1_oe_n, gp_pin_1_out});
    dq_pull_low = 1'h1;
    tk(2);
    chk("dq", 2'h0, {dq_oe_n, dq_out});
    dq_pull_low = 1'h0;
    thr_we = 1'h1;
    thr_sel_high = 1'h1;
    thr_wdata = 16'h1388;
    tk(1);
    thr_we = 1'h0;
    tk(2);
    chk("thr write", 32'h1388_8000, {high_threshold, low_threshold});
    thr_sel_high = 1'h0;
    thr_wdata = 16'hFF38;
    thr_we = 1'h1;
    tk(1);
    thr_we = 1'h0;
    tk(2);
    chk("thr low", 32'h1388_FF38, {high_threshold, low_threshold});
    rst_n = 1'h0;
    tk(1);
    chk("thr lost", 32'h7FFF_8000, {high_threshold, low_threshold});
    end_sim();
  end
endmodule : tb
